//--- design/gcs_consts.svh
// Summary of operation
// R1: in manual mode setting the scan start bit runs one scan
// R2: scan start copies every master magnitude and direction to slave
// R3: scan start bit clears when coil 11 service begins
// R4: clear point is the same whether or not last gauge enabled
// R5: clearing at coil 11 leaves two coil periods before scan ends
// R6: after a manual scan the sequencer idles until start set again
// R7: writing one to a still-set start bit is ignored
// R8: in automatic mode start bit writes do nothing
// R9: mode select one means automatic repeating, zero means manual
// R10: wait mode keeps clocks and scanning running as normal
// R11: in wait mode coils keep latest magnitude and direction
// R12: software enables sync interrupt to wake from wait in manual mode
// R13: stop entry clears every gauge enable bit
// R14: stop entry leaves all other register bits unchanged
// R15: stop entry resets sequencer so a fresh scan starts later; a manual scan stopped before coil 11 keeps start set and the sequencer idle
// R16: a scan updates twelve coils in order, one period each
// R17: sync flag sets at coil 11 in both modes, may interrupt
// R18: manual mode transfers master to slave at each gauge start
// R19: scan start bit reads one from set until coil 11 clear
`ifndef GCS_CONSTS_SVH
`define GCS_CONSTS_SVH
`define GCS_ADDR_SCAN_CTRL 4'h0
`define GCS_ADDR_GAUGE_EN 4'h1
`define GCS_ADDR_MASK 4'h2
`define GCS_ADDR_IRQ 4'h3
`define GCS_ADDR_CTRL 4'h4
`define GCS_ADDR_COIL 4'h8
`define GCS_ADDR_CPTR 4'h9
`define GCS_ADDR_CMAG 4'ha
`define GCS_ADDR_CDIR 4'hb
`define GCS_BIT_START 0
`define GCS_BIT_AUTO 1
`define GCS_BIT_SYNC_CLR 2
`define GCS_BIT_SYNC_FLAG 3
`define GCS_BIT_SYNC_IE 4
`define GCS_BIT_CLK_SEL0 5
`define GCS_BIT_CLK_SEL1 6
`define GCS_SCAN_CTRL_RESET 8'h00
`define GCS_SYNC_COIL 4'ha
`define GCS_LAST_COIL 4'hb
`define GCS_BASE_DIV 512
`endif

//--- design/gcs_pkg.sv
package gcs_pkg;
  typedef enum logic [2:0] {
    GCS_IDLE = 3'b001,
    GCS_XFER = 3'b010,
    GCS_COIL = 3'b100
  } gcs_state_e;
endpackage

//--- design/gcs_coil_mem.sv
`timescale 1ns/1ps
module gcs_coil_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 12
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [3:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  // the address ports are four bits wide
  if (DEPTH > 16 || DEPTH < 1) begin : g_bad_depth
    $error("depth out of range");
  end
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

//--- design/gcs_scan_ctrl.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "gcs_consts.svh"
module gcs_scan_ctrl #(
  parameter int NUM_COILS = 12,
  parameter int MAG_WIDTH = 8,
  parameter int BASE_DIV = `GCS_BASE_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // low power
  input wire logic stop_entry,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // interrupt
  output logic irq,
  // coil drive, one coil per update period
  output logic [3:0] coil_index,
  output logic [MAG_WIDTH-1:0] coil_magnitude,
  output logic coil_direction,
  output logic coil_drive_on,
  output logic coil_update
);
  localparam int DW = MAG_WIDTH + 1;

  // a slot shorter than four clocks would outrun the coil memory read path
  localparam bit BAD_PARAM = NUM_COILS != 12 || MAG_WIDTH < 1 || MAG_WIDTH > 8
                             || BASE_DIV < 4 || BASE_DIV > 1024;
  if (BAD_PARAM) begin : g_bad_param
    $error("unsupported parameters");
  end

  typedef struct packed {
    gcs_pkg::gcs_state_e state;
    logic scan_start_bit;
    logic auto_scan_select;
    logic sync_flag;
    logic sync_seen;
    logic sync_interrupt_enable;
    logic [1:0] clk_sel;
    logic [5:0] gauge_enable_reg;
    logic [5:0] irq_mask;
    logic [5:0] irq_status;
    logic [11:0] written;
    logic [3:0] coil_ptr;
    logic [3:0] coil;
    logic [12:0] div_cnt;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] coil_index;
    logic [MAG_WIDTH-1:0] coil_magnitude;
    logic coil_direction;
    logic coil_drive_on;
    logic coil_update;
  } gcs_regs_s;

  gcs_regs_s r;
  gcs_regs_s next_r;

  // ***************************************************
  // master and slave buffers
  // ***************************************************
  logic [DW-1:0] master [12];
  logic [DW-1:0] slave [12];
  logic [11:0] load_slave;
  logic [DW-1:0] slave_rd;
  logic [DW-1:0] master_wdata;
  logic master_wr;

  assign master_wr = wr && (addr == `GCS_ADDR_CMAG || addr == `GCS_ADDR_CDIR);
  always_comb begin
    master_wdata = master[r.coil_ptr];
    if (addr == `GCS_ADDR_CMAG) begin
      master_wdata[MAG_WIDTH-1:0] = wdata[MAG_WIDTH-1:0];
    end else begin
      master_wdata[MAG_WIDTH] = wdata[0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_coil
      always_ff @(posedge clock) begin
        if (!resetn) begin
          master[gi] <= '0;
          slave[gi] <= '0;
        end else begin
          if (master_wr && r.coil_ptr == 4'(gi)) begin
            master[gi] <= master_wdata;
          end
          if (load_slave[gi]) begin
            slave[gi] <= master[gi];
          end
        end
      end
    end
  endgenerate

  // current coil's slave word, refreshed every clock; the drive reads it back registered
  gcs_coil_mem #(.WIDTH(DW), .DEPTH(12)) u_mem (
    .clock(clock),
    .wr_en(1'b1),
    .wr_addr(r.coil),
    .wr_data(slave[r.coil]),
    .rd_addr(r.coil),
    .rd_data(slave_rd)
  );

  // ***************************************************
  // sequencer and register logic
  // ***************************************************
  logic tick;
  logic [12:0] div_max;
  logic start_req;
  logic gauge_first;
  logic sync_set;

  always_comb begin
    div_max = 13'((BASE_DIV << r.clk_sel) - 1);
    tick = (r.div_cnt == div_max);
    gauge_first = ~r.coil[0];
    sync_set = (r.state == gcs_pkg::GCS_XFER) && (r.coil == `GCS_SYNC_COIL);
    // R7 ignore while set, R8 no effect in auto
    start_req = wr && addr == `GCS_ADDR_SCAN_CTRL && wdata[`GCS_BIT_START]
                && !r.scan_start_bit && !r.auto_scan_select;
  end

  always_comb begin
    next_r = r;
    load_slave = '0;
    next_r.coil_update = 1'b0;
    // R10 divider free running in wait mode too
    next_r.div_cnt = tick ? 13'h0000 : r.div_cnt + 13'h0001;

    if (start_req) begin
      // R1 manual start
      next_r.scan_start_bit = 1'b1;
      // R2 transfer all coils
      load_slave = 12'hfff;
    end

    case (r.state)
      gcs_pkg::GCS_IDLE: begin
        // R9 auto repeats, manual waits for start
        if (r.auto_scan_select || start_req) begin
          next_r.state = gcs_pkg::GCS_XFER;
          next_r.coil = 4'h0;
          next_r.div_cnt = 13'h0000;
        end
      end
      gcs_pkg::GCS_XFER: begin
        // R18 transfer at each gauge start, pair written in auto
        if (gauge_first && (!r.auto_scan_select
            || (r.written[r.coil] && r.written[r.coil + 4'h1]))) begin
          load_slave[r.coil] = 1'b1;
          load_slave[r.coil + 4'h1] = 1'b1;
          next_r.written[r.coil] = 1'b0;
          next_r.written[r.coil + 4'h1] = 1'b0;
        end
        next_r.state = gcs_pkg::GCS_COIL;
        // R3 R4 clear at coil 11 regardless of enables
        if (r.coil == `GCS_SYNC_COIL) begin
          next_r.scan_start_bit = 1'b0;
          // R17 sync flag in either mode
          next_r.sync_flag = 1'b1;
          next_r.irq_status[0] = 1'b1;
        end
      end
      gcs_pkg::GCS_COIL: begin
        // R16 one period per coil, R5 two periods left after coil 11
        if (tick) begin
          next_r.coil_update = 1'b1;
          if (r.coil == `GCS_LAST_COIL) begin
            // R6 idle after manual scan, unless software set start again in the tail
            if (r.auto_scan_select || next_r.scan_start_bit) begin
              next_r.state = gcs_pkg::GCS_XFER;
            end else begin
              next_r.state = gcs_pkg::GCS_IDLE;
            end
            next_r.coil = 4'h0;
          end else begin
            next_r.state = gcs_pkg::GCS_XFER;
            next_r.coil = r.coil + 4'h1;
          end
        end
      end
      default: next_r.state = gcs_pkg::GCS_IDLE;
    endcase

    if (master_wr) begin
      next_r.written[r.coil_ptr] = (addr == `GCS_ADDR_CMAG) | r.written[r.coil_ptr];
    end

    // register writes
    if (wr) begin
      case (addr)
        `GCS_ADDR_SCAN_CTRL: begin
          next_r.auto_scan_select = wdata[`GCS_BIT_AUTO];
          next_r.sync_interrupt_enable = wdata[`GCS_BIT_SYNC_IE];
          next_r.clk_sel = {wdata[`GCS_BIT_CLK_SEL1], wdata[`GCS_BIT_CLK_SEL0]};
          // set of the flag in this cycle wins over the clear
          if (wdata[`GCS_BIT_SYNC_CLR] && r.sync_seen && !sync_set) begin
            next_r.sync_flag = 1'b0;
            // a later clear needs a fresh read that shows the flag set
            next_r.sync_seen = 1'b0;
          end
        end
        `GCS_ADDR_GAUGE_EN: next_r.gauge_enable_reg = wdata[5:0];
        `GCS_ADDR_MASK: next_r.irq_mask = wdata[5:0];
        `GCS_ADDR_CPTR: next_r.coil_ptr = (wdata[3:0] > `GCS_LAST_COIL) ? `GCS_LAST_COIL : wdata[3:0];
        default: ;
      endcase
    end

    // register reads, data one cycle later
    next_r.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `GCS_ADDR_SCAN_CTRL: begin
          // R19 start bit reads back until cleared
          next_r.rdata = {1'b0, r.clk_sel, r.sync_interrupt_enable, r.sync_flag, 1'b0,
                          r.auto_scan_select, r.scan_start_bit};
          next_r.sync_seen = r.sync_flag;
        end
        `GCS_ADDR_GAUGE_EN: next_r.rdata = {2'b00, r.gauge_enable_reg};
        `GCS_ADDR_MASK: next_r.rdata = {2'b00, r.irq_mask};
        `GCS_ADDR_IRQ: begin
          next_r.rdata = {2'b00, r.irq_status};
          // read clears, but a new event this cycle survives
          next_r.irq_status[0] = sync_set;
        end
        `GCS_ADDR_COIL: next_r.rdata = {4'h0, r.coil};
        `GCS_ADDR_CPTR: next_r.rdata = {4'h0, r.coil_ptr};
        `GCS_ADDR_CMAG: next_r.rdata = 8'(master[r.coil_ptr][MAG_WIDTH-1:0]);
        `GCS_ADDR_CDIR: next_r.rdata = {7'h00, master[r.coil_ptr][MAG_WIDTH]};
        default: next_r.rdata = 8'h00;
      endcase
    end

    // R13 R14 R15 stop clears enables, sequencer and pair written flags only
    if (stop_entry) begin
      next_r.gauge_enable_reg = 6'h00;
      next_r.state = gcs_pkg::GCS_IDLE;
      next_r.coil = 4'h0;
      next_r.div_cnt = 13'h0000;
      next_r.written = '0;
    end

    // R17 R12 sync interrupt, plus masked status
    next_r.irq = (next_r.sync_flag & next_r.sync_interrupt_enable)
                 | |(next_r.irq_status & next_r.irq_mask);
    // R11 coils keep slave values, disabled gauges stay off
    next_r.coil_index = r.coil;
    next_r.coil_magnitude = slave_rd[MAG_WIDTH-1:0];
    next_r.coil_direction = slave_rd[MAG_WIDTH];
    next_r.coil_drive_on = (r.state == gcs_pkg::GCS_COIL) && r.gauge_enable_reg[r.coil[3:1]];
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
      r.state <= gcs_pkg::GCS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq = r.irq;
  assign coil_index = r.coil_index;
  assign coil_magnitude = r.coil_magnitude;
  assign coil_direction = r.coil_direction;
  assign coil_drive_on = r.coil_drive_on;
  assign coil_update = r.coil_update;
endmodule

//--- sim/gcs_scan_ctrl_props.sv
`timescale 1ns/1ps
module gcs_props (
  // clock, reset, stop
  input wire logic clock,
  input wire logic resetn,
  input wire logic stop_entry,
  // register port
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  // coil drive
  input wire logic [3:0] coil_index,
  input wire logic coil_drive_on,
  input wire logic coil_update
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // the shortest divider still gives four clocks per slot
  sequence quiet_slot;
    !coil_update [*3];
  endsequence
  sequence bus_recent;
    $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(rd) || $past(rd, 2) || $past(rd, 3);
  endsequence
  sequence slot_edge;
    coil_update || $past(coil_update) || $past(coil_update, 2) || $past(stop_entry)
      || $past(stop_entry, 2)
      || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endsequence
  chk_read_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_index_top: assert property (coil_index <= 4'hb)
    else $error("coil index past last coil");
  chk_index_step: assert property (
    $changed(coil_index) |-> coil_index == $past(coil_index) + 4'h1 || coil_index == 4'h0)
    else $error("coil order broken");
  chk_index_cause: assert property ($changed(coil_index) |-> slot_edge)
    else $error("coil index moved inside a slot");
  chk_slot_gap: assert property (coil_update |=> quiet_slot)
    else $error("coil slot too short");
  chk_stop_reset: assert property (
    stop_entry |-> ##2 (coil_index == 4'h0 && !coil_drive_on))
    else $error("stop did not reset sequencer");
  chk_irq_rise: assert property (
    $rose(irq) |-> coil_index == 4'ha || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("interrupt rose away from sync coil");
  chk_irq_fall: assert property ($fell(irq) |-> bus_recent)
    else $error("interrupt fell without software access");
endmodule
bind gcs_scan_ctrl gcs_props chk_u (
  .clock(clock), .resetn(resetn), .stop_entry(stop_entry), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .coil_index(coil_index), .coil_drive_on(coil_drive_on),
  .coil_update(coil_update));

//--- sim/gcs_coil_model.sv
`timescale 1ns/1ps
module gcs_coil_model (
  // coil drive from the sequencer
  input wire logic clock,
  input wire logic [3:0] coil_index,
  input wire logic [7:0] coil_magnitude,
  input wire logic coil_direction,
  input wire logic coil_drive_on,
  input wire logic coil_update
);
  // ***
  // sample and hold per coil
  // ***
  logic [7:0] held_mag [12] = '{default: 8'h00};
  logic held_dir [12] = '{default: 1'b0};
  int upd_count = 0;
  always @(posedge clock) begin
    if (coil_update === 1'b1) begin
      upd_count <= upd_count + 1;
      // a disabled gauge spends its slot but its coil is left alone
      if (coil_drive_on === 1'b1 && coil_index < 4'hc) begin
        held_mag[coil_index] <= coil_magnitude;
        held_dir[coil_index] <= coil_direction;
      end
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic stop_entry = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, cmag, rv;
  logic [3:0] coil_index;
  logic irq, cdir, con, cupd;
  int err_total = 0;
  int checked = 0;
  int base, n0;
  always #20 clock = ~clock;
  // short divider keeps a slot at four clocks
  gcs_scan_ctrl #(.BASE_DIV(4)) dut_u (
    .clock(clock), .resetn(resetn), .stop_entry(stop_entry), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .coil_index(coil_index),
    .coil_magnitude(cmag), .coil_direction(cdir), .coil_drive_on(con), .coil_update(cupd));
  gcs_coil_model coil_u (
    .clock(clock), .coil_index(coil_index), .coil_magnitude(cmag), .coil_direction(cdir),
    .coil_drive_on(con), .coil_update(cupd));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    // read data stand for the whole next cycle; take them once settled
    @(negedge clock);
    rv = rdata;
    @(posedge clock);
  endtask
  task automatic results();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd_reg(4'h0);
    chk("scan_ctrl_rst", rv, 8'h00);
    wr_reg(4'h4, 8'h5a);
    rd_reg(4'h4);
    chk("unmapped", rv, 8'h00);
  endtask
  task automatic t_manual();
    int n;
    // last gauge off: its slots still run
    wr_reg(4'h1, 8'h1f);
    for (int i = 0; i < 12; i++) begin
      wr_reg(4'h9, 8'(i));
      wr_reg(4'ha, 8'(8'h20 + i));
      wr_reg(4'hb, 8'(i % 2));
    end
    base = coil_u.upd_count;
    wr_reg(4'h0, 8'h11);
    rd_reg(4'h0);
    chk("start_held", 8'(rv[0]), 8'h01);
    wr_reg(4'h0, 8'h11);
    n = 0;
    while (coil_index !== 4'ha && n < 300) begin
      @(negedge clock);
      n++;
    end
    n0 = coil_u.upd_count;
    chk("sync_wait", 8'(n < 300), 8'h01);
    @(posedge clock);
    rd_reg(4'h0);
    chk("start_clr", 8'(rv[0]), 8'h00);
    chk("sync_flag", 8'(rv[3]), 8'h01);
    repeat (24) @(posedge clock);
    chk("scan_len", 8'(coil_u.upd_count - base), 8'h0c);
    chk("tail", 8'(coil_u.upd_count - n0), 8'h02);
    chk("irq_sync", 8'(irq), 8'h01);
    for (int i = 0; i < 12; i++) begin
      chk("mag", coil_u.held_mag[i], i < 10 ? 8'(8'h20 + i) : 8'h00);
      chk("dir", 8'(coil_u.held_dir[i]), i < 10 ? 8'(i % 2) : 8'h00);
    end
    wr_reg(4'h0, 8'h14);
    @(posedge clock);
    chk("irq_clr", 8'(irq), 8'h00);
    wr_reg(4'h2, 8'h01);
    @(posedge clock);
    chk("irq_mask", 8'(irq), 8'h01);
    rd_reg(4'h3);
    chk("status", rv, 8'h01);
    @(posedge clock);
    chk("irq_read", 8'(irq), 8'h00);
  endtask
  task automatic t_auto();
    wr_reg(4'h1, 8'h3f);
    base = coil_u.upd_count;
    wr_reg(4'h0, 8'h03);
    repeat (120) @(posedge clock);
    chk("auto_rerun", 8'(coil_u.upd_count - base > 24), 8'h01);
    rd_reg(4'h0);
    chk("auto_sync", 8'(rv[3]), 8'h01);
  endtask
  task automatic t_stop();
    stop_entry <= 1'b1;
    @(posedge clock);
    stop_entry <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk("stop_idx", 8'(coil_index), 8'h00);
    chk("stop_drive", 8'(con), 8'h00);
    @(posedge clock);
    rd_reg(4'h1);
    chk("ger_clr", rv, 8'h00);
    rd_reg(4'h2);
    chk("mask_kept", rv, 8'h01);
    rd_reg(4'h0);
    chk("mode_kept", 8'(rv[1]), 8'h01);
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    results();
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_manual();
    t_auto();
    t_stop();
    results();
  end
endmodule
